/* File: inc/dts_defines.svh */
// register map, field positions, reset values and timing constants
`ifndef DTS_DEFINES_SVH
`define DTS_DEFINES_SVH

`define DTS_CLK_PERIOD_PS     100000
`define DTS_IN_LAT_NS         150
`define DTS_OUT_LAT_NS        20
`define DTS_PULSE_WIDTH_MS    10
`define DTS_PULSE_CYCLES      ((`DTS_PULSE_WIDTH_MS * 64'd1000000000) / `DTS_CLK_PERIOD_PS)

`define DTS_ADR_CTRL          8'h00
`define DTS_ADR_STATUS        8'h04
`define DTS_ADR_IRQ_STAT      8'h08
`define DTS_ADR_IRQ_MASK      8'h0C
`define DTS_ADR_ENG_BASE      8'h10
`define DTS_ENG_STRIDE        8'h10
`define DTS_OFS_CFG           8'h00
`define DTS_OFS_WIDTH         8'h04
`define DTS_OFS_PAT           8'h08

`define DTS_CTRL_RUN          0
`define DTS_CTRL_CASC_LSB     1
`define DTS_CTRL_CASC_MSB     2
`define DTS_CTRL_OUT_POL      3
`define DTS_CTRL_IN_POL       4
`define DTS_CTRL_RESET        32'h0000_0000

`define DTS_CFG_MODE_LSB      0
`define DTS_CFG_MODE_MSB      2
`define DTS_CFG_POL           3
`define DTS_CFG_CHAN_LSB      4
`define DTS_CFG_CHAN_MSB      7
`define DTS_CFG_CLKCH_LSB     8
`define DTS_CFG_CLKCH_MSB     11
`define DTS_CFG_MATCH_LSB     12
`define DTS_CFG_MATCH_MSB     19
`define DTS_WID_MIN_LSB       0
`define DTS_WID_MIN_MSB       15
`define DTS_WID_MAX_LSB       16
`define DTS_WID_MAX_MSB       31
`define DTS_PAT1_LSB          0
`define DTS_PAT2_LSB          16

`define DTS_IRQ_TRIG          0
`define DTS_IRQ_ENG_A         1
`define DTS_IRQ_ENG_B         2
`define DTS_IRQ_EXT           3
`define DTS_IRQ_BITS          4

`endif

/* File: inc/dts_pkg.sv */
// types shared by the trigger sequencer modules
`default_nettype none
package dts_pkg;
	typedef enum logic [2:0] {
		DTS_M_EDGE,
		DTS_M_PULSE,
		DTS_M_SEQ,
		DTS_M_PROTO,
		DTS_M_EXT
	} dts_emode_t;
	typedef enum logic [1:0] {
		DTS_C_A_THEN_B,
		DTS_C_B_THEN_A,
		DTS_C_A_AND_B,
		DTS_C_A_OR_B
	} dts_casc_t;
	typedef enum logic [1:0] {
		DTS_S_IDLE,
		DTS_S_FIRST,
		DTS_S_SECOND
	} dts_seq_t;
endpackage : dts_pkg
`default_nettype wire

/* File: inc/dts_eng_if.sv */
// link between the sequencer and one trigger engine
`default_nettype none
interface dts_eng_if;
	logic        arm;
	logic        fire;
	logic [31:0] cfg;
	logic [31:0] width;
	logic [31:0] pat;
	modport seq (output arm, output cfg, output width, output pat,
		input fire);
	modport eng (input arm, input cfg, input width, input pat,
		output fire);
endinterface : dts_eng_if
`default_nettype wire

/* File: rtl/dts_delay.sv */
// fixed latency shift line, output from a register
`include "dts_defines.svh"
`default_nettype none
module dts_delay #(
	parameter int W = 1,
	parameter int D = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] din_i,
	output logic      [W-1:0] dout_o
);
	logic [W-1:0] stage [D];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < D; i++) stage[i] <= '0;
		end else begin
			stage[0] <= din_i;
			for (int i = 1; i < D; i++) stage[i] <= stage[i-1];
		end
	end

	assign dout_o = stage[D-1];
endmodule : dts_delay
`default_nettype wire

/* File: rtl/dts_engine.sv */
// one trigger engine: edge, pulse width, sequence, serial match, external
`include "dts_defines.svh"
`default_nettype none
module dts_engine #(
	parameter int NCH = 9
) (
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	input  wire logic [NCH-1:0] probe_i,
	input  wire logic           ext_evt_i,
	dts_eng_if.eng              bus
);
	function automatic logic pick(input logic [NCH-1:0] v,
			input logic [3:0] idx);
		pick = (32'(idx) < NCH) ? v[idx] : 1'b0;
	endfunction : pick

	logic [2:0]     mode;
	logic           pol;
	logic           sig;
	logic           sig_q;
	logic           clk_ch;
	logic           clk_ch_q;
	logic [15:0]    cnt;
	logic           stage;
	logic [7:0]     shreg;
	logic           hit;
	logic [NCH-1:0] pat1;
	logic [NCH-1:0] pat2;

	assign mode   = bus.cfg[`DTS_CFG_MODE_MSB:`DTS_CFG_MODE_LSB];
	assign pol    = bus.cfg[`DTS_CFG_POL];
	assign sig    = pick(probe_i, bus.cfg[`DTS_CFG_CHAN_MSB:`DTS_CFG_CHAN_LSB])
		^ pol;
	assign clk_ch = pick(probe_i,
		bus.cfg[`DTS_CFG_CLKCH_MSB:`DTS_CFG_CLKCH_LSB]);
	assign pat1   = bus.pat[`DTS_PAT1_LSB +: NCH];
	assign pat2   = bus.pat[`DTS_PAT2_LSB +: NCH];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sig_q    <= 1'b0;
			clk_ch_q <= 1'b0;
		end else begin
			sig_q    <= sig;
			clk_ch_q <= clk_ch;
		end
	end

	// one detection mode at a time, chosen by the mode field
	always_comb begin
		hit = 1'b0;
		unique case (mode)
			dts_pkg::DTS_M_EDGE:  hit = sig & ~sig_q;
			dts_pkg::DTS_M_PULSE: hit = ~sig & sig_q
				& (cnt >= bus.width[`DTS_WID_MIN_MSB:`DTS_WID_MIN_LSB])
				& (cnt <= bus.width[`DTS_WID_MAX_MSB:`DTS_WID_MAX_LSB]);
			dts_pkg::DTS_M_SEQ:   hit = stage & (probe_i == pat2);
			dts_pkg::DTS_M_PROTO: hit = clk_ch & ~clk_ch_q
				& ({shreg[6:0], sig}
				== bus.cfg[`DTS_CFG_MATCH_MSB:`DTS_CFG_MATCH_LSB]);
			dts_pkg::DTS_M_EXT:   hit = ext_evt_i;
			default:              hit = 1'b0;
		endcase
	end

	// counters are held at zero while disarmed, so a pulse already high is timed only from arming
	always_ff @(posedge clk_i) begin
		if (rst_i || !bus.arm) begin
			cnt   <= '0;
			stage <= 1'b0;
			shreg <= '0;
		end else if (mode == dts_pkg::DTS_M_PULSE) begin
			cnt <= !sig ? '0 : (&cnt ? cnt : cnt + 16'h0001);
		end else if (mode == dts_pkg::DTS_M_SEQ) begin
			if (!stage) begin
				stage <= (probe_i == pat1);
				cnt   <= '0;
			end else if (cnt >= bus.width[`DTS_WID_MAX_MSB:`DTS_WID_MAX_LSB])
				begin
				stage <= 1'b0;
			end else begin
				cnt <= cnt + 16'h0001;
			end
		end else if (mode == dts_pkg::DTS_M_PROTO && clk_ch && !clk_ch_q)
			begin
			shreg <= {shreg[6:0], sig};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) bus.fire <= 1'b0;
		else       bus.fire <= bus.arm & hit;
	end
endmodule : dts_engine
`default_nettype wire

/* File: rtl/dts_top.sv */
// dual trigger sequencer: two engines, cascade, trigger in and out
// Functional notes
// - each engine runs exactly one of edge, pulse width, sequence, serial match or external mode; here mode codes 5 to 7 run none of them.
// - in the ordered cascades the second engine stays disarmed until the first has fired.
// - in the conjunctive cascade a trigger needs both engines fired, in any order.
// - in the disjunctive cascade the first engine to fire triggers.
// - every trigger, in every mode, starts a capture and emits an output pulse.
// - the output pulse lasts a fixed 10 ms.
// - software selects whether the output pulse is active high or low.
// - probe events reach the engines after a fixed input latency.
// - the output asserts a fixed latency after the trigger is detected.
// - an active edge on the trigger input, polarity chosen by software, starts acquisition.
// - the trigger input reaches the engines after the same fixed input latency.
//
// Chosen here: the address map and the Wishbone register port.
`include "dts_defines.svh"
`default_nettype none
module dts_top #(
	parameter int          NCH          = 9,
	parameter int unsigned PULSE_CYCLES = 32'(`DTS_PULSE_CYCLES)
) (
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	input  wire logic [7:0]     wb_adr_i,
	input  wire logic [31:0]    wb_dat_i,
	input  wire logic [3:0]     wb_sel_i,
	input  wire logic           wb_we_i,
	input  wire logic           wb_cyc_i,
	input  wire logic           wb_stb_i,
	output logic      [31:0]    wb_dat_o,
	output logic                wb_ack_o,
	input  wire logic [NCH-1:0] probe_i,
	input  wire logic           ext_trig_i,
	output logic                trig_out_o,
	output logic                capture_start_o,
	output logic                irq_o
);
	localparam int IN_LAT_RAW  = `DTS_IN_LAT_NS * 1000 / `DTS_CLK_PERIOD_PS;
	localparam int OUT_LAT_RAW = `DTS_OUT_LAT_NS * 1000 / `DTS_CLK_PERIOD_PS;
	localparam int IN_LAT_CYC  = (IN_LAT_RAW < 1) ? 1 : IN_LAT_RAW;
	// the detect flop itself supplies one cycle of the output latency
	localparam int OUT_LAT_CYC = (OUT_LAT_RAW < 1) ? 1 : OUT_LAT_RAW;

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] sel);
		for (int b = 0; b < 4; b++)
			merge[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
	endfunction : merge

	function automatic logic eng_hit(input logic [7:0] adr,
			input int e, input logic [7:0] ofs);
		eng_hit = adr == 8'(`DTS_ADR_ENG_BASE + e * `DTS_ENG_STRIDE + ofs);
	endfunction : eng_hit

	// bus access
	logic                    acc;
	logic                    wr;
	logic                    rd;
	logic [31:0]             ctrl;
	logic [31:0]             eng_cfg   [2];
	logic [31:0]             eng_width [2];
	logic [31:0]             eng_pat   [2];
	logic [`DTS_IRQ_BITS-1:0] irq_stat;
	logic [`DTS_IRQ_BITS-1:0] irq_mask;
	logic [`DTS_IRQ_BITS-1:0] irq_evt;
	logic [31:0]             next_rdata;

	// probe and trigger-in path
	logic [NCH-1:0]          probe_d;
	logic                    ext_d;
	logic                    ext_q;
	logic                    ext_evt;

	// sequencing
	dts_pkg::dts_seq_t       state;
	dts_pkg::dts_casc_t      casc;
	logic                    run;
	logic [1:0]              fired;
	logic [1:0]              fire;
	logic [1:0]              next_arm;
	logic                    detect;
	logic                    detect_d;
	logic [31:0]             pulse_cnt;
	logic                    pulse_on;

	assign acc  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr   = acc & wb_we_i;
	assign rd   = acc & ~wb_we_i;
	assign casc = dts_pkg::dts_casc_t'(
		ctrl[`DTS_CTRL_CASC_MSB:`DTS_CTRL_CASC_LSB]);
	assign run  = ctrl[`DTS_CTRL_RUN];

	// probes and the trigger input share one latency so they stay aligned
	dts_delay #(
		.W (NCH + 1),
		.D (IN_LAT_CYC)
	) u_in_lat (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.din_i  ({ext_trig_i, probe_i}),
		.dout_o ({ext_d, probe_d})
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) ext_q <= 1'b0;
		else       ext_q <= ext_d;
	end

	// one sample at the sampling rate is enough to see a minimum pulse
	assign ext_evt = ctrl[`DTS_CTRL_IN_POL] ? (~ext_d & ext_q)
		: (ext_d & ~ext_q);

	dts_eng_if eng_a ();
	dts_eng_if eng_b ();

	assign eng_a.cfg   = eng_cfg[0];
	assign eng_a.width = eng_width[0];
	assign eng_a.pat   = eng_pat[0];
	assign eng_a.arm   = next_arm[0];
	assign eng_b.cfg   = eng_cfg[1];
	assign eng_b.width = eng_width[1];
	assign eng_b.pat   = eng_pat[1];
	assign eng_b.arm   = next_arm[1];
	assign fire        = {eng_b.fire, eng_a.fire};

	dts_engine #(
		.NCH (NCH)
	) u_eng_a (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.probe_i   (probe_d),
		.ext_evt_i (ext_evt),
		.bus       (eng_a.eng)
	);

	dts_engine #(
		.NCH (NCH)
	) u_eng_b (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.probe_i   (probe_d),
		.ext_evt_i (ext_evt),
		.bus       (eng_b.eng)
	);

	// which engines listen in each phase of the cascade
	always_comb begin
		next_arm = 2'b00;
		unique case (state)
			dts_pkg::DTS_S_IDLE: next_arm = 2'b00;
			dts_pkg::DTS_S_FIRST: begin
				unique case (casc)
					dts_pkg::DTS_C_A_THEN_B: next_arm = 2'b01;
					dts_pkg::DTS_C_B_THEN_A: next_arm = 2'b10;
					dts_pkg::DTS_C_A_AND_B:  next_arm = ~fired;
					dts_pkg::DTS_C_A_OR_B:   next_arm = 2'b11;
				endcase
			end
			dts_pkg::DTS_S_SECOND: begin
				next_arm = (casc == dts_pkg::DTS_C_B_THEN_A) ? 2'b01
					: 2'b10;
			end
		endcase
	end

	// detect is a one-cycle pulse; it also drops run back to idle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state  <= dts_pkg::DTS_S_IDLE;
			fired  <= 2'b00;
			detect <= 1'b0;
		end else begin
			detect <= 1'b0;
			unique case (state)
				dts_pkg::DTS_S_IDLE: begin
					fired <= 2'b00;
					if (run) state <= dts_pkg::DTS_S_FIRST;
				end
				dts_pkg::DTS_S_FIRST: begin
					fired <= fired | fire;
					if (!run) begin
						state <= dts_pkg::DTS_S_IDLE;
					end else if (casc == dts_pkg::DTS_C_A_OR_B) begin
						if (|fire) begin
							detect <= 1'b1;
							state  <= dts_pkg::DTS_S_IDLE;
						end
					end else if (casc == dts_pkg::DTS_C_A_AND_B) begin
						if (&(fired | fire)) begin
							detect <= 1'b1;
							state  <= dts_pkg::DTS_S_IDLE;
						end
					end else if (|fire) begin
						state <= dts_pkg::DTS_S_SECOND;
					end
				end
				dts_pkg::DTS_S_SECOND: begin
					fired <= fired | fire;
					if (!run) begin
						state <= dts_pkg::DTS_S_IDLE;
					end else if (|fire) begin
						detect <= 1'b1;
						state  <= dts_pkg::DTS_S_IDLE;
					end
				end
			endcase
		end
	end

	dts_delay #(
		.W (1),
		.D (OUT_LAT_CYC)
	) u_out_lat (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.din_i  (detect),
		.dout_o (detect_d)
	);

	// pulse timer; a new trigger during a pulse restarts the full width
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pulse_cnt <= '0;
			pulse_on  <= 1'b0;
		end else if (detect_d) begin
			pulse_cnt <= PULSE_CYCLES - 32'd1;
			pulse_on  <= 1'b1;
		end else if (pulse_cnt != '0) begin
			pulse_cnt <= pulse_cnt - 32'd1;
		end else begin
			pulse_on  <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) trig_out_o <= 1'b0;
		else       trig_out_o <= next_pulse_level();
	end

	function automatic logic next_pulse_level();
		logic on;
		on = detect_d | (pulse_on & (pulse_cnt != '0));
		next_pulse_level = on ^ ctrl[`DTS_CTRL_OUT_POL];
	endfunction : next_pulse_level

	always_ff @(posedge clk_i) begin
		if (rst_i) capture_start_o <= 1'b0;
		else       capture_start_o <= detect_d;
	end

	// control register; run self-clears when the trigger is declared
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= `DTS_CTRL_RESET;
		end else begin
			if (wr && wb_adr_i == `DTS_ADR_CTRL)
				ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
			if (detect)
				ctrl[`DTS_CTRL_RUN] <= 1'b0;
		end
	end

	for (genvar e = 0; e < 2; e++) begin : g_eng_regs
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				eng_cfg[e]   <= '0;
				eng_width[e] <= '0;
				eng_pat[e]   <= '0;
			end else if (wr) begin
				if (eng_hit(wb_adr_i, e, `DTS_OFS_CFG))
					eng_cfg[e] <= merge(eng_cfg[e], wb_dat_i, wb_sel_i);
				if (eng_hit(wb_adr_i, e, `DTS_OFS_WIDTH))
					eng_width[e] <= merge(eng_width[e], wb_dat_i, wb_sel_i);
				if (eng_hit(wb_adr_i, e, `DTS_OFS_PAT))
					eng_pat[e] <= merge(eng_pat[e], wb_dat_i, wb_sel_i);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask <= '0;
		end else if (wr && wb_adr_i == `DTS_ADR_IRQ_MASK && wb_sel_i[0]) begin
			irq_mask <= wb_dat_i[`DTS_IRQ_BITS-1:0];
		end
	end

	always_comb begin
		irq_evt = '0;
		irq_evt[`DTS_IRQ_TRIG]  = detect;
		irq_evt[`DTS_IRQ_ENG_A] = fire[0];
		irq_evt[`DTS_IRQ_ENG_B] = fire[1];
		irq_evt[`DTS_IRQ_EXT]   = ext_evt;
	end

	// read clears, but an event in the same cycle stays set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= '0;
		end else if (rd && wb_adr_i == `DTS_ADR_IRQ_STAT) begin
			irq_stat <= irq_evt;
		end else begin
			irq_stat <= irq_stat | irq_evt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) irq_o <= 1'b0;
		else       irq_o <= |((irq_stat | irq_evt) & irq_mask);
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (wb_adr_i == `DTS_ADR_CTRL) begin
			next_rdata = ctrl;
		end else if (wb_adr_i == `DTS_ADR_STATUS) begin
			next_rdata[0] = run;
			next_rdata[2:1] = state;
			next_rdata[4:3] = fired;
			next_rdata[5] = pulse_on;
			next_rdata[6] = ext_d;
		end else if (wb_adr_i == `DTS_ADR_IRQ_STAT) begin
			next_rdata[`DTS_IRQ_BITS-1:0] = irq_stat;
		end else if (wb_adr_i == `DTS_ADR_IRQ_MASK) begin
			next_rdata[`DTS_IRQ_BITS-1:0] = irq_mask;
		end else begin
			for (int e = 0; e < 2; e++) begin
				if (eng_hit(wb_adr_i, e, `DTS_OFS_CFG))
					next_rdata = eng_cfg[e];
				if (eng_hit(wb_adr_i, e, `DTS_OFS_WIDTH))
					next_rdata = eng_width[e];
				if (eng_hit(wb_adr_i, e, `DTS_OFS_PAT))
					next_rdata = eng_pat[e];
			end
		end
	end

	// unmapped addresses still ack, reading zero and ignoring writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= acc;
			if (rd) wb_dat_o <= next_rdata;
		end
	end
endmodule : dts_top
`default_nettype wire

/* File: bench/dts_top_asserts.sv */
// concurrent checks on the trigger sequencer top ports
`default_nettype none
module dts_top_asserts #(
	parameter int unsigned PULSE_CYCLES = 8
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic        wb_we_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        trig_out_o,
	input wire logic        capture_start_o,
	input wire logic        irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic        pol;
	logic [31:0] left;
	logic        act;
	assign act = trig_out_o ^ pol;
	// mirror of the output polarity bit, taken on the accepted write
	always_ff @(posedge clk_i) begin
		if (rst_i)
			pol <= 1'b0;
		else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
			wb_adr_i == 8'h00 && wb_sel_i[0])
			pol <= wb_dat_i[3];
	end
	// pulse cycles still owed, counting the current one
	always_ff @(posedge clk_i) begin
		if (rst_i)
			left <= 32'h0000_0000;
		else if (capture_start_o)
			left <= PULSE_CYCLES - 32'h0000_0001;
		else if (left != 32'h0000_0000)
			left <= left - 32'h0000_0001;
	end
	property p_cap_act;
		capture_start_o |-> act;
	endproperty
	a_cap_act: assert property (p_cap_act)
		else $error("output idle at capture start");
	property p_cap_one;
		capture_start_o |=> !capture_start_o;
	endproperty
	a_cap_one: assert property (p_cap_one)
		else $error("capture start longer than one cycle");
	property p_hold;
		left != 32'h0000_0000 |-> act;
	endproperty
	a_hold: assert property (p_hold)
		else $error("output pulse ended early");
	// a polarity write may take one cycle to reach the idle level
	property p_end;
		left == 32'h0000_0000 && !capture_start_o && $stable(pol) |-> !act;
	endproperty
	a_end: assert property (p_end)
		else $error("output pulse too long");
	property p_rise;
		$rose(act) && $stable(pol) |-> capture_start_o;
	endproperty
	a_rise: assert property (p_rise)
		else $error("output went active without a capture");
	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("bus request not answered next cycle");
	property p_ack_one;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one)
		else $error("acknowledge longer than one cycle");
	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("acknowledge without a request");
	c_cap: cover property (capture_start_o);
	c_cap_inv: cover property (capture_start_o && pol);
	c_irq: cover property ($rose(irq_o));
endmodule : dts_top_asserts

bind dts_top dts_top_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) u_dts_top_asserts (
	.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .trig_out_o(trig_out_o),
	.capture_start_o(capture_start_o), .irq_o(irq_o));
`default_nettype wire

/* File: bench/dts_instr.sv */
// far-side instrument: drives the trigger input, times the trigger output
`default_nettype none
module dts_instr (
	input  wire logic clk_i,
	input  wire logic in_act_i,
	input  wire logic out_pol_i,
	input  wire logic trig_out_i,
	output logic      ext_trig_o,
	output var int    last_width_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic hit = 1'b0;
	int   run_n = 0;
	// rests at the inactive level so only a pulse makes an active edge
	assign ext_trig_o = hit ? in_act_i : ~in_act_i;
	// whole sample periods, down to a single period, the shortest pulse the input sees
	task automatic pulse(input int len);
		hit <= 1'b1;
		repeat (len) @(posedge clk_i);
		hit <= 1'b0;
	endtask : pulse
	always @(posedge clk_i) begin
		if (trig_out_i ^ out_pol_i)
			run_n <= run_n + 1;
		else if (run_n != 0) begin
			last_width_o <= run_n;
			run_n <= 0;
		end
	end
endmodule : dts_instr
`default_nettype wire

/* File: bench/dts_top_test.sv */
// self-checking bench for the dual trigger sequencer
`default_nettype none
`define CHK(what, exp, got) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		miscompares++; \
		$display("[ERR] %s expected %0h seen %0h", what, exp, got); \
	end \
end
module dts_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned PW = 8;
	// stimulus edge to the edge that samples capture start
	localparam int LAT = 6;
	localparam logic [2:0] CASC_EXP [4] = '{3'h4, 3'h2, 3'h2, 3'h1};
	localparam int PLEN [4] = '{1, 2, 4, 5};
	localparam int PEXP [4] = '{0, 1, 1, 0};
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [3:0]  wb_sel_i = 4'hF;
	logic        wb_we_i = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [8:0]  probe_i = 9'h000;
	logic        ext_trig_i;
	logic        trig_out_o;
	logic        capture_start_o;
	logic        irq_o;
	logic        in_act = 1'b1;
	logic        out_pol = 1'b0;
	logic [31:0] rd;
	int          last_w;
	int          cyc_n = 0;
	int          cap_seen = 0;
	int          cap_at = 0;
	int          t0;
	int          n0;
	int          miscompares = 0;
	int          check_count = 0;
	always #50 clk_i = ~clk_i;
	dts_top #(.NCH(9), .PULSE_CYCLES(PW)) u_dts_top (
		.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .probe_i(probe_i), .ext_trig_i(ext_trig_i),
		.trig_out_o(trig_out_o), .capture_start_o(capture_start_o),
		.irq_o(irq_o));
	dts_instr u_dts_instr (
		.clk_i(clk_i), .in_act_i(in_act), .out_pol_i(out_pol),
		.trig_out_i(trig_out_o), .ext_trig_o(ext_trig_i),
		.last_width_o(last_w));
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (capture_start_o === 1'b1) begin
			cap_seen <= cap_seen + 1;
			cap_at <= cyc_n;
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	task automatic wb_xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int k;
		wb_adr_i <= a;
		wb_we_i <= w;
		wb_dat_i <= d;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 16);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
		if (k >= 16) begin
			miscompares++;
			wrap_up();
		end
	endtask : wb_xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb_xfer(a, 1'b1, d);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
		input string what);
		wb_xfer(a, 1'b0, 32'h0000_0000);
		`CHK(what, e, rd)
	endtask : rdchk
	task automatic arm(input logic [1:0] c);
		wr(8'h00, {27'h0, ~in_act, out_pol, c, 1'b1});
		repeat (2) @(posedge clk_i);
	endtask : arm
	// a negative channel sends the pulse through the trigger input
	task automatic poke(input int ch, input int len);
		t0 = cyc_n;
		n0 = cap_seen;
		if (ch < 0)
			u_dts_instr.pulse(len);
		else begin
			probe_i[ch] <= 1'b1;
			repeat (len) @(posedge clk_i);
			probe_i[ch] <= 1'b0;
		end
		repeat (LAT + PW) @(posedge clk_i);
	endtask : poke
	// first pattern for one cycle, then idle for gap cycles, then the second
	task automatic seq_try(input int gap);
		n0 = cap_seen;
		probe_i <= 9'h001;
		@(posedge clk_i);
		probe_i <= 9'h000;
		repeat (gap) @(posedge clk_i);
		probe_i <= 9'h002;
		@(posedge clk_i);
		probe_i <= 9'h000;
		repeat (LAT + PW) @(posedge clk_i);
	endtask : seq_try
	// data on channel 0, clock on channel 1, most significant bit first
	task automatic ser_try(input logic [7:0] v);
		n0 = cap_seen;
		for (int b = 7; b >= 0; b--) begin
			probe_i <= {8'h00, v[b]};
			@(posedge clk_i);
			probe_i <= {8'h01, v[b]};
			@(posedge clk_i);
		end
		probe_i <= 9'h000;
		repeat (LAT + PW) @(posedge clk_i);
	endtask : ser_try
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdchk(8'h00, 32'h0000_0000, "ctrl reset");
		rdchk(8'h0C, 32'h0000_0000, "mask reset");
		wr(8'hF0, 32'hFFFF_FFFF);
		rdchk(8'hF0, 32'h0000_0000, "unmapped");
		`CHK("idle level", 1'b0, trig_out_o)
		$display("registers done");
		wr(8'h10, 32'h0000_0000);
		wr(8'h20, 32'h0000_0010);
		for (int c = 0; c < 4; c++) begin
			arm(c[1:0]);
			for (int s = 0; s < 3; s++) begin
				poke((s == 1) ? 0 : 1, 2);
				`CHK("cascade", CASC_EXP[c][s], cap_seen - n0)
				if (c == 3 && s == 0)
					`CHK("latency", LAT, cap_at - t0)
			end
		end
		`CHK("width", PW, last_w)
		`CHK("irq masked", 1'b0, irq_o)
		rdchk(8'h08, 32'h0000_0007, "irq status");
		rdchk(8'h08, 32'h0000_0000, "irq cleared");
		$display("cascade done");
		wr(8'h0C, 32'h0000_0001);
		out_pol <= 1'b1;
		@(posedge clk_i);
		arm(2'h3);
		`CHK("idle inverted", 1'b1, trig_out_o)
		poke(0, 2);
		`CHK("inverted capture", 1, cap_seen - n0)
		`CHK("inverted width", PW, last_w)
		`CHK("irq raised", 1'b1, irq_o)
		rdchk(8'h08, 32'h0000_0003, "irq events");
		`CHK("irq dropped", 1'b0, irq_o)
		$display("polarity done");
		wr(8'h10, 32'h0000_0001);
		wr(8'h14, 32'h0004_0002);
		wr(8'h20, 32'h0000_0005);
		for (int i = 0; i < 4; i++) begin
			arm(2'h3);
			poke(0, PLEN[i]);
			`CHK("pulse width mode", PEXP[i], cap_seen - n0)
		end
		$display("pulse mode done");
		wr(8'h18, 32'h0002_0001);
		for (int i = 0; i < 2; i++) begin
			wr(8'h10, 32'h0000_0002);
			arm(2'h3);
			seq_try(2 + 6 * i);
			`CHK("sequence mode", 1 - i, cap_seen - n0)
			wr(8'h10, 32'h000A_5103);
			arm(2'h3);
			ser_try(i ? 8'hA4 : 8'hA5);
			`CHK("serial mode", 1 - i, cap_seen - n0)
		end
		$display("sequence and serial done");
		wr(8'h10, 32'h0000_0004);
		for (int p = 0; p < 2; p++) begin
			in_act <= (p == 0);
			@(posedge clk_i);
			arm(2'h3);
			poke(-1, 1);
			`CHK("ext capture", 1, cap_seen - n0)
			`CHK("ext latency", LAT, cap_at - t0)
		end
		$display("trigger input done");
		wrap_up();
	end
endmodule : dts_top_test
`default_nettype wire
